// *** verilog/anbh_host.sv ***
/*
 Host controller for an asynchronous NAND target: drives CE#, CLE, ALE, WE#,
 RE#, WP# and DQ, reads R/B#. Read bytes pass through an 8-word FIFO.
 Assumes pins arrive asynchronously and a pull-up on R/B# outside.
*/
module anbh_host
    import anbh_pkg::*;
#(
    parameter int NUM_CE = 2,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire anbh_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output anbh_rsp_t rsp,
    output logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic wp_enable,
    output logic busy_seen,
    output logic [NUM_CE-1:0] ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic re_n,
    output logic wp_n,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic [7:0] dq_in,
    input wire logic rb_n
);
    initial begin
        if (NUM_CE < 1 || NUM_CE > (1 << ANBH_CE_W)) begin
            $error("NUM_CE out of range");
        end
    end

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_WPWAIT} anbh_state_t;

    function automatic logic [NUM_CE-1:0] ce_decode(input logic [ANBH_CE_W-1:0] t);
        logic [NUM_CE-1:0] v;
        v = '1;
        for (int i = 0; i < NUM_CE; i++) begin
            if (t == ANBH_CE_W'(i)) v[i] = 1'b0;
        end
        return v;
    endfunction

    anbh_state_t st_reg, st_next;
    anbh_req_t cur_reg, cur_next;
    logic [ANBH_CNT_W-1:0] cnt_reg, cnt_next;
    logic [NUM_CE-1:0] ce_n_reg, ce_n_next;
    logic cle_reg, cle_next, ale_reg, ale_next, we_reg, we_next, re_reg, re_next;
    logic oe_reg, oe_next, wp_reg, wp_next;
    logic [7:0] dqo_reg, dqo_next;
    logic [7:0] dq_s1, dq_s2;
    logic rb_s1, rb_s2, wpe_s1, wpe_s2;
    logic busy_reg;
    logic f_valid, f_ready;
    anbh_rsp_t f_data;

    anbh_fifo #(.WIDTH($bits(anbh_rsp_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk), .rst(rst), .in_data(f_data), .in_valid(f_valid), .in_ready(f_ready),
        .out_data(rsp), .out_valid(rsp_valid), .out_ready(rsp_ready)
    );

    // Two-flop synchronisers; the first stage feeds only the second
    always_ff @(posedge clk) begin
        dq_s1 <= dq_in;
        dq_s2 <= dq_s1;
        rb_s1 <= rb_n;
        rb_s2 <= rb_s1;
        wpe_s1 <= wp_enable;
        wpe_s2 <= wpe_s1;
        busy_reg <= rst ? 1'b0 : !rb_s2;
    end

    always_comb begin
        st_next = st_reg;
        cur_next = cur_reg;
        cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        ce_n_next = ce_n_reg;
        cle_next = cle_reg;
        ale_next = ale_reg;
        we_next = we_reg;
        re_next = re_reg;
        oe_next = oe_reg;
        wp_next = wp_reg;
        dqo_next = dqo_reg;
        f_valid = 1'b0;
        f_data = '{target: cur_reg.target, data: dq_s2};
        req_ready = 1'b0;
        unique case (st_reg)
            ST_IDLE: begin
                // WP moves only between sequences with the target ready
                if (wpe_s2 != wp_reg && !busy_reg) begin
                    wp_next = wpe_s2;
                    cnt_next = ANBH_CNT_W'(ANBH_T_WW_CYC);
                    st_next = ST_WPWAIT;
                end else begin
                    req_ready = 1'b1;
                    if (req_valid) begin
                        cur_next = req;
                        // Only the addressed target is enabled
                        ce_n_next = ce_decode(req.target);
                        // CLE and ALE never both high
                        cle_next = req.kind == ANBH_KIND_CMD;
                        ale_next = req.kind == ANBH_KIND_ADDR;
                        oe_next = req.kind != ANBH_KIND_RDATA;
                        dqo_next = req.data;
                        cnt_next = ANBH_CNT_W'(ANBH_T_WH_CYC);
                        st_next = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // Read waits for room so no byte is lost in the FIFO
                if (cnt_reg == '0 && (cur_reg.kind != ANBH_KIND_RDATA || f_ready)) begin
                    if (cur_reg.kind == ANBH_KIND_RDATA) begin
                        re_next = 1'b0;
                        cnt_next = ANBH_CNT_W'(ANBH_T_RP_CYC);
                    end else begin
                        we_next = 1'b0;
                        cnt_next = ANBH_CNT_W'(ANBH_T_WP_CYC);
                    end
                    st_next = ST_LOW;
                end
            end
            ST_LOW: begin
                // RE low time must outlast the two-flop DQ synchroniser delay
                if (cnt_reg == '0) begin
                    we_next = 1'b1;
                    re_next = 1'b1;
                    if (cur_reg.kind == ANBH_KIND_RDATA) begin
                        f_valid = 1'b1;
                    end
                    cnt_next = ANBH_CNT_W'(ANBH_T_REH_CYC);
                    st_next = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (cnt_reg == '0) begin
                    // Release shared pins between cycles
                    ce_n_next = '1;
                    cle_next = 1'b0;
                    ale_next = 1'b0;
                    oe_next = 1'b0;
                    st_next = ST_IDLE;
                end
            end
            ST_WPWAIT: begin
                if (cnt_reg == '0) st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= ST_IDLE;
            cur_reg <= '0;
            cnt_reg <= '0;
            ce_n_reg <= '1;
            cle_reg <= 1'b0;
            ale_reg <= 1'b0;
            we_reg <= 1'b1;
            re_reg <= 1'b1;
            oe_reg <= 1'b0;
            wp_reg <= 1'b0;
            dqo_reg <= '0;
        end else begin
            st_reg <= st_next;
            cur_reg <= cur_next;
            cnt_reg <= cnt_next;
            ce_n_reg <= ce_n_next;
            cle_reg <= cle_next;
            ale_reg <= ale_next;
            we_reg <= we_next;
            re_reg <= re_next;
            oe_reg <= oe_next;
            wp_reg <= wp_next;
            dqo_reg <= dqo_next;
        end
    end

    assign ce_n = ce_n_reg;
    assign cle = cle_reg;
    assign ale = ale_reg;
    assign we_n = we_reg;
    assign re_n = re_reg;
    assign dq_oe = oe_reg;
    assign dq_out = dqo_reg;
    assign wp_n = wp_reg;
    assign busy_seen = busy_reg;

    AST_NO_CLE_ALE: assert property (@(posedge clk) disable iff (rst) !(cle && ale))
        else $error("CLE and ALE both high");
    AST_WE_RE: assert property (@(posedge clk) disable iff (rst) !(!we_n && !re_n))
        else $error("WE and RE low together");
    AST_WE_CE: assert property (@(posedge clk) disable iff (rst) !we_n |-> !(&ce_n))
        else $error("WE pulse without chip enable");
    AST_ONE_CE: assert property (@(posedge clk) disable iff (rst) $countones(~ce_n) <= 1)
        else $error("Two targets enabled");
    AST_RE_NOOE: assert property (@(posedge clk) disable iff (rst) !re_n |-> !dq_oe)
        else $error("Host drives DQ during read");
    AST_WE_OE: assert property (@(posedge clk) disable iff (rst) $rose(we_n) |-> dq_oe)
        else $error("DQ not driven at WE rise");
    AST_WP_WAIT: assert property (@(posedge clk) disable iff (rst)
        $changed(wp_n) |-> (&ce_n) [*8])
        else $error("Command too soon after WP change");
    AST_RELEASE: assert property (@(posedge clk) disable iff (rst)
        $rose(&ce_n) |-> !dq_oe && !cle && !ale)
        else $error("Pins not released with CE high");
    COV_CMD: cover property (@(posedge clk) cle && $rose(we_n));
    COV_ADDR: cover property (@(posedge clk) ale && $rose(we_n));
    COV_READ: cover property (@(posedge clk) $rose(re_n));
    COV_WP: cover property (@(posedge clk) $rose(wp_n));
endmodule

// *** shared/anbh_pkg.sv ***
/*
 Package for the asynchronous NAND bus host: bus timing counts, command codes,
 request and response carriers.
 Assumes a 200 MHz clk and a NAND target on the far side of the pins.
*/
package anbh_pkg;
    localparam int ANBH_CLK_MHZ = 200;
    // Strobe low and high half-periods and the WP settling wait, in ns; least times round up
    localparam int ANBH_T_WP_NS = 15;
    localparam int ANBH_T_WH_NS = 15;
    localparam int ANBH_T_RP_NS = 20;
    localparam int ANBH_T_REH_NS = 15;
    localparam int ANBH_T_WW_NS = 100;
    localparam int ANBH_T_WP_CYC = (ANBH_T_WP_NS * ANBH_CLK_MHZ + 999) / 1000;
    localparam int ANBH_T_WH_CYC = (ANBH_T_WH_NS * ANBH_CLK_MHZ + 999) / 1000;
    localparam int ANBH_T_RP_CYC = (ANBH_T_RP_NS * ANBH_CLK_MHZ + 999) / 1000;
    localparam int ANBH_T_REH_CYC = (ANBH_T_REH_NS * ANBH_CLK_MHZ + 999) / 1000;
    localparam int ANBH_T_WW_CYC = (ANBH_T_WW_NS * ANBH_CLK_MHZ + 999) / 1000;
    localparam int ANBH_CNT_W = 8;
    localparam int ANBH_CE_W = 2;
    localparam logic [7:0] ANBH_CMD_STATUS = 8'h70;
    localparam logic [7:0] ANBH_CMD_STATUS_ENH = 8'h78;
    localparam logic [7:0] ANBH_CMD_READ_MODE = 8'h00;
    localparam logic [1:0] ANBH_KIND_CMD = 2'h0;
    localparam logic [1:0] ANBH_KIND_ADDR = 2'h1;
    localparam logic [1:0] ANBH_KIND_WDATA = 2'h2;
    localparam logic [1:0] ANBH_KIND_RDATA = 2'h3;

    typedef struct packed {
        logic [1:0] kind;
        logic [ANBH_CE_W-1:0] target;
        logic [7:0] data;
    } anbh_req_t;

    typedef struct packed {
        logic [ANBH_CE_W-1:0] target;
        logic [7:0] data;
    } anbh_rsp_t;
endpackage

// *** verilog/anbh_fifo.sv ***
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
module anbh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("DEPTH must be a power of two, at least 2");
        end
    end
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        in_ready = (wr_reg - rd_reg) != (AW + 1)'(DEPTH);
        out_valid = wr_reg != rd_reg;
        out_data = mem_reg[rd_reg[AW-1:0]];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

// *** testbench/anbh_nand_model.sv ***
/*
 NAND target model for the host bench: NUM_CE targets, one die each, 8-byte cache.
 Assumes host pins as inputs and busy per target driven by the bench.
*/
module anbh_nand_model
    import anbh_pkg::*;
#(
    parameter int NUM_CE = 2,
    parameter logic [7:0] STAT_READY = 8'hE0,
    parameter logic [7:0] STAT_BUSY = 8'h80
) (
    input wire logic [NUM_CE-1:0] ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic wp_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    input wire logic [NUM_CE-1:0] busy,
    output logic [7:0] dq_in,
    output logic rb_n,
    output logic [NUM_CE-1:0][7:0] last_cmd,
    output logic [NUM_CE-1:0][7:0] last_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cache [NUM_CE][8];
    logic [2:0] wptr [NUM_CE];
    logic [2:0] rptr [NUM_CE];
    logic [NUM_CE-1:0] stat_mode;
    logic [7:0] out_byte;
    logic is_stat;
    logic prog_ok;
    initial begin
        last_cmd = '0;
        last_addr = '0;
        stat_mode = '0;
        out_byte = 8'h00;
        for (int t = 0; t < NUM_CE; t++) begin
            wptr[t] = 3'h0;
            rptr[t] = 3'h0;
        end
    end
    assign is_stat = dq_out == ANBH_CMD_STATUS || dq_out == ANBH_CMD_STATUS_ENH;
    // Program and erase gate follows wp_n, whatever ce_n does
    assign prog_ok = wp_n;
    // Pull-up wins only when no die is busy; standby waits on the same
    assign rb_n = ~|busy;
    // No strobe pin: async mode only, one shared byte lane
    // Released bus shows the inverse, so a stale sample cannot match
    assign dq_in = (~&ce_n && !re_n && !cle && !ale && we_n) ? out_byte : ~out_byte;
    always @(posedge we_n) begin
        for (int t = 0; t < NUM_CE; t++) begin
            // Own enable only; CLE with ALE latches nothing
            if (!ce_n[t] && re_n) begin
                if (cle && !ale) begin
                    if (!busy[t] || is_stat) begin
                        last_cmd[t] <= dq_out;
                        stat_mode[t] <= is_stat;
                        if (dq_out == ANBH_CMD_READ_MODE) begin
                            rptr[t] <= 3'h0;
                        end
                    end
                end else if (ale && !cle) begin
                    if (!busy[t] || stat_mode[t]) begin
                        last_addr[t] <= dq_out;
                    end
                end else if (!cle && !ale && !busy[t]) begin
                    cache[t][wptr[t]] <= dq_out;
                    wptr[t] <= wptr[t] + 3'h1;
                end
            end
        end
    end
    always @(negedge re_n) begin
        for (int t = 0; t < NUM_CE; t++) begin
            if (!ce_n[t] && we_n && !cle && !ale) begin
                if (stat_mode[t]) begin
                    out_byte <= busy[t] ? STAT_BUSY : STAT_READY;
                end else if (!busy[t]) begin
                    out_byte <= cache[t][rptr[t]];
                    rptr[t] <= rptr[t] + 3'h1;
                end
            end
        end
    end
endmodule

// *** testbench/anbh_host_tb.sv ***
/*
 Self-checking bench for the NAND host with a target model on its pins.
 Assumes the shared package and both modules compiled first.
*/
module anbh_host_tb
    import anbh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    anbh_req_t req = '0;
    logic req_valid = 1'b0;
    logic rsp_ready = 1'b0;
    logic wp_enable = 1'b0;
    logic [1:0] busy = 2'h0;
    logic req_ready, rsp_valid, busy_seen, cle, ale, we_n, re_n, wp_n, dq_oe, rb_n;
    anbh_rsp_t rsp;
    logic [1:0] ce_n;
    logic [7:0] dq_out, dq_in;
    logic [1:0][7:0] last_cmd, last_addr;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    anbh_host i_anbh_host (.clk(clk), .rst(rst), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rsp(rsp), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .wp_enable(wp_enable), .busy_seen(busy_seen), .ce_n(ce_n), .cle(cle), .ale(ale),
        .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .rb_n(rb_n));
    anbh_nand_model i_anbh_nand_model (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .re_n(re_n), .wp_n(wp_n), .dq_out(dq_out), .dq_oe(dq_oe), .busy(busy),
        .dq_in(dq_in), .rb_n(rb_n), .last_cmd(last_cmd), .last_addr(last_addr));
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Whole run needs about 450 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors++;
            results();
        end
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic send(input logic [1:0] kind, input logic [1:0] tgt, input logic [7:0] d);
        int n = 0;
        @(negedge clk);
        req = '{kind: kind, target: tgt, data: d};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) errors++;
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    task automatic wait_idle();
        int n = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) errors++;
    endtask
    task automatic rx(input logic [7:0] exp, input logic [1:0] tgt);
        int n = 0;
        @(negedge clk);
        while (rsp_valid !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) errors++;
        chk_byte(rsp.data, exp);
        chk_byte({6'h00, rsp.target}, {6'h00, tgt});
        rsp_ready = 1'b1;
        @(negedge clk);
        rsp_ready = 1'b0;
    endtask
    task automatic t_reset();
        @(negedge clk);
        chk_byte({6'h00, ce_n}, 8'h03);
        chk_bit(we_n & re_n, 1'b1);
        chk_bit(dq_oe, 1'b0);
        chk_bit(wp_n, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_wp();
        wp_enable = 1'b1;
        repeat (5) @(negedge clk);
        chk_bit(wp_n, 1'b1);
        chk_bit(req_ready, 1'b0);
        // Settling wait is ANBH_T_WW_CYC cycles after the WP change
        repeat (15) @(negedge clk);
        chk_bit(req_ready, 1'b0);
        repeat (10) @(negedge clk);
        chk_bit(req_ready, 1'b1);
        $display("test write protect done");
    endtask
    task automatic t_cmd_addr();
        send(ANBH_KIND_CMD, 2'h1, 8'h90);
        wait_idle();
        chk_byte(last_cmd[1], 8'h90);
        chk_byte(last_cmd[0], 8'h00);
        send(ANBH_KIND_ADDR, 2'h0, 8'h5A);
        wait_idle();
        chk_byte(last_addr[0], 8'h5A);
        chk_byte(last_addr[1], 8'h00);
        chk_byte({6'h00, ce_n}, 8'h03);
        $display("test command address done");
    endtask
    task automatic t_data();
        for (int i = 0; i < 8; i++) send(ANBH_KIND_WDATA, 2'h0, 8'hA0 + 8'(i));
        send(ANBH_KIND_CMD, 2'h0, ANBH_CMD_READ_MODE);
        // Sink stalls, so the ninth read waits for room
        for (int i = 0; i < 9; i++) send(ANBH_KIND_RDATA, 2'h0, 8'h00);
        repeat (30) @(negedge clk);
        chk_bit(req_ready, 1'b0);
        for (int i = 0; i < 9; i++) rx(8'hA0 + 8'(i % 8), 2'h0);
        $display("test data fifo done");
    endtask
    task automatic t_busy();
        busy = 2'h1;
        repeat (5) @(negedge clk);
        chk_bit(busy_seen, 1'b1);
        send(ANBH_KIND_WDATA, 2'h0, 8'h33);
        send(ANBH_KIND_CMD, 2'h0, ANBH_CMD_STATUS);
        send(ANBH_KIND_RDATA, 2'h0, 8'h00);
        rx(8'h80, 2'h0);
        busy = 2'h0;
        repeat (5) @(negedge clk);
        chk_bit(busy_seen, 1'b0);
        send(ANBH_KIND_CMD, 2'h0, ANBH_CMD_READ_MODE);
        send(ANBH_KIND_RDATA, 2'h0, 8'h00);
        rx(8'hA0, 2'h0);
        $display("test busy done");
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_wp();
        t_cmd_addr();
        t_data();
        t_busy();
        results();
    end
endmodule
